// ---- design/gpa_defines.svh ----
`ifndef GPA_DEFINES_SVH
`define GPA_DEFINES_SVH
// Register byte offsets
`define GPA_OFF_CFG        6'h00
`define GPA_OFF_MODE       6'h04
`define GPA_OFF_SD_CFG     6'h08
`define GPA_OFF_ANEG_CFG   6'h0c
`define GPA_OFF_NP_CFG     6'h10
`define GPA_OFF_LB_CFG     6'h14
`define GPA_OFF_ANEG_STAT  6'h18
`define GPA_OFF_NP_STAT    6'h1c
`define GPA_OFF_LINK_STAT  6'h20
`define GPA_OFF_LDOWN_CNT  6'h24
`define GPA_OFF_STICKY     6'h28
`define GPA_OFF_TP_CFG     6'h2c
`define GPA_OFF_TP_STAT    6'h30
// Field positions
`define GPA_B_ENA          0
`define GPA_B_SGMII        0
`define GPA_B_UNIDIR       1
`define GPA_B_LOS_REACT    0
`define GPA_B_LOS_POL      1
`define GPA_B_LOS_SRC      2
`define GPA_B_LOOP         0
`define GPA_F_TP_HI        2
`define GPA_F_TP_LO        0
`define GPA_B_AN_ENA       0
`define GPA_B_AN_RESTART   1
`define GPA_B_NP_LOADED    0
`define GPA_B_AN_DONE      0
`define GPA_B_EXCH_DONE    2
`define GPA_B_LINK         0
`define GPA_B_SYNC         1
`define GPA_B_SD           2
`define GPA_B_ST_LDOWN     0
`define GPA_B_ST_PAGE      1
`define GPA_B_TP_LOCK      0
`define GPA_B_TP_ERR       1
`define GPA_W_HI           31
`define GPA_W_LO           16
`define GPA_NP_BIT         15
`define GPA_SGMII_LINK_BIT 15
// Reset values
`define GPA_RST_WORD       16'h0000
`define GPA_RST_LOS_POL    1'b1
`define GPA_RST_RDATA      32'h0000_0000
// Timing
`define GPA_CLK_PERIOD_NS  8
`define GPA_LT_SGMII_NS    1600000
`define GPA_LT_SERDES_NS   10000000
`define GPA_SYNC_LOSE      2'h3
`define GPA_SYNC_GAIN      3'h4
// Jitter pattern codes and lengths
`define GPA_JP_HF          3'h1
`define GPA_JP_LF          3'h2
`define GPA_JP_MF          3'h3
`define GPA_JP_CR_LONG     3'h4
`define GPA_JP_CR_SHORT    3'h5
`define GPA_SYM_D21_5      8'hb5
`define GPA_SYM_K28_7      8'hfc
`define GPA_SYM_K28_5      8'hbc
`define GPA_SYM_D10_2      8'h4a
`define GPA_FRM_LONG       11'h5dc
`define GPA_FRM_SHORT      11'h040
`define GPA_FRM_GAP        11'h00c
`define GPA_LFSR_SEED      8'h01
`define GPA_LFSR_TAPS      8'hb8
`endif

// ---- design/gpa_pcs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gpa_defines.svh"
// Operation
// - Layer works only when enabled; mode bit picks serial GMII or 1000BASE-X.
// - One-way mode transmits data whatever the receive link state.
// - Negotiation runs only while enabled; restart pulse bit restarts it.
// - Local base page word advertised; local next page word sent per next page.
// - After base pages, page flag sets and partner base word becomes readable.
// - After next page exchange, page flag sets and partner next page captured.
// - After last page, machine goes idle-detect and exchange-done bit sets.
// - Idle-detect moves to link-good one link timer period later.
// - Link-good state raises the negotiation done status bit.
// - Link status is sync state, or partner base word bit 15 in SGMII.
// - Out of link-good states one timer period: sticky flag, counter increments.
// - Link timer is 1.6 ms in SGMII mode and 10 ms otherwise.
// - Sync status readable; dropped when lane data cannot be decoded.
// - With reaction enabled, loss of signal restarts receive and stops frames.
// - Configurable polarity applied to signal detect before use.
// - Select bit takes signal detect from SerDes or optical receiver pin.
// - Present signal detect value readable as a status bit.
// - Loop enable routes transmit coding path into receive path.
// - Non-zero pattern select replaces operation: codes 1 to 5 pick one of five jitter patterns, 6 and 7 send the K28.5 byte as data, ctrl low.
// - While patterns run, error and lock conditions recorded in test status.
module gpa_pcs #(
  parameter int unsigned LT_SGMII_CYC  = `GPA_LT_SGMII_NS / `GPA_CLK_PERIOD_NS,
  parameter int unsigned LT_SERDES_CYC = `GPA_LT_SERDES_NS / `GPA_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Avalon-MM register slave
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output var  logic [31:0]       avs_readdata,
  output var  logic              avs_waitrequest,
  // MAC side
  input  wire gpa_pkg::gpa_gmii_t mac_tx,
  output var  gpa_pkg::gpa_gmii_t mac_rx,
  // SerDes lane
  input  wire gpa_pkg::gpa_lane_t lane_rx,
  output var  gpa_pkg::gpa_lane_t lane_tx,
  // Signal detect pins: SerDes and optical receiver
  input  wire logic              sd_serdes,
  input  wire logic              sd_optical
);
  localparam logic [20:0] LT_SGMII  = LT_SGMII_CYC[20:0];
  localparam logic [20:0] LT_SERDES = LT_SERDES_CYC[20:0];

  function automatic logic in_link_state(input gpa_pkg::gpa_an_state_t s);
    in_link_state = (s == gpa_pkg::AN_LINK_OK) || (s == gpa_pkg::AN_FORCED_UP);
  endfunction

  // Configuration
  logic        ena_q, sgmii_q, unidir_q, los_react_q, los_pol_q, los_src_q;
  logic        an_ena_q, restart_q, np_loaded_q, loop_q;
  logic [15:0] adv_q, local_np_q, lp_adv_q, lp_np_q;
  logic [2:0]  jp_sel_q;
  // Status
  logic        page_q, ldown_q, exch_done_q, sync_q, tp_lock_q, tp_err_q;
  logic [7:0]  ldown_cnt_q, tp_cnt_q;
  gpa_pkg::gpa_an_state_t an_q;
  logic [20:0] tmr_q, down_q;
  logic [1:0]  bad_q;
  logic [2:0]  good_q;
  logic [10:0] pat_cnt_q;
  logic [7:0]  lfsr_q;
  logic        pat_phase_q, frm_q;
  logic [15:0] cfg_tx_q;
  gpa_pkg::gpa_lane_t lane_tx_q, rx_src;
  gpa_pkg::gpa_gmii_t mac_rx_q;
  logic [31:0] rdata_q;
  logic        wait_q;

  // Bus handshake: one wait cycle, then the access completes
  logic req, acc, wr;
  assign req = avs_read | avs_write;
  assign acc = req & ~wait_q;
  assign wr  = acc & avs_write;
  function automatic logic wr_at(input logic [5:0] a, input logic [5:0] off);
    wr_at = (a == off);
  endfunction
  logic w_cfg, w_mode, w_sd, w_an, w_np, w_lb, w_st, w_tpc, w_tps;
  assign w_cfg  = wr & wr_at(avs_address, `GPA_OFF_CFG);
  assign w_mode = wr & wr_at(avs_address, `GPA_OFF_MODE);
  assign w_sd   = wr & wr_at(avs_address, `GPA_OFF_SD_CFG);
  assign w_an   = wr & wr_at(avs_address, `GPA_OFF_ANEG_CFG);
  assign w_np   = wr & wr_at(avs_address, `GPA_OFF_NP_CFG);
  assign w_lb   = wr & wr_at(avs_address, `GPA_OFF_LB_CFG);
  assign w_st   = wr & wr_at(avs_address, `GPA_OFF_STICKY);
  assign w_tpc  = wr & wr_at(avs_address, `GPA_OFF_TP_CFG);
  assign w_tps  = wr & wr_at(avs_address, `GPA_OFF_TP_STAT);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end
  assign avs_waitrequest = wait_q;

  // Signal detect synchronisers; the first stage feeds only the second
  logic [1:0] sd_raw, sd_m_q, sd_s_q;
  assign sd_raw = {sd_optical, sd_serdes};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sd_sync
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          sd_m_q[gi] <= 1'b0;
          sd_s_q[gi] <= 1'b0;
        end else begin
          sd_m_q[gi] <= sd_raw[gi];
          sd_s_q[gi] <= sd_m_q[gi];
        end
      end
    end
  endgenerate
  logic sd_val, los;
  assign sd_val = (los_src_q ? sd_s_q[1] : sd_s_q[0]) ~^ los_pol_q;
  assign los    = los_react_q & ~sd_val;

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ena_q <= 1'b0; sgmii_q <= 1'b0; unidir_q <= 1'b0;
      los_react_q <= 1'b0; los_pol_q <= `GPA_RST_LOS_POL; los_src_q <= 1'b0;
      an_ena_q <= 1'b0; adv_q <= `GPA_RST_WORD; local_np_q <= `GPA_RST_WORD;
      loop_q <= 1'b0; jp_sel_q <= 3'h0;
    end else begin
      if (w_cfg) ena_q <= avs_writedata[`GPA_B_ENA];
      if (w_mode) begin
        sgmii_q  <= avs_writedata[`GPA_B_SGMII];
        unidir_q <= avs_writedata[`GPA_B_UNIDIR];
      end
      if (w_sd) begin
        los_react_q <= avs_writedata[`GPA_B_LOS_REACT];
        los_pol_q   <= avs_writedata[`GPA_B_LOS_POL];
        los_src_q   <= avs_writedata[`GPA_B_LOS_SRC];
      end
      if (w_an) begin
        an_ena_q <= avs_writedata[`GPA_B_AN_ENA];
        adv_q    <= avs_writedata[`GPA_W_HI:`GPA_W_LO];
      end
      if (w_np) local_np_q <= avs_writedata[`GPA_W_HI:`GPA_W_LO];
      if (w_lb) loop_q <= avs_writedata[`GPA_B_LOOP];
      if (w_tpc) jp_sel_q <= avs_writedata[`GPA_F_TP_HI:`GPA_F_TP_LO];
    end
  end

  // Receive source: loop takes the registered transmit lane
  assign rx_src = loop_q ? lane_tx_q : lane_rx;

  // Synchronisation: lose on three bad symbols, regain on four good
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_q <= 1'b0; bad_q <= 2'h0; good_q <= 3'h0;
    end else if (!ena_q || los) begin
      sync_q <= 1'b0; bad_q <= 2'h0; good_q <= 3'h0;
    end else if (rx_src.valid) begin
      if (rx_src.err) begin
        good_q <= 3'h0;
        if (bad_q == `GPA_SYNC_LOSE - 2'h1) begin
          sync_q <= 1'b0;
          bad_q  <= 2'h0;
        end else if (sync_q) begin
          bad_q <= bad_q + 2'h1;
        end
      end else begin
        bad_q <= 2'h0;
        if (good_q == `GPA_SYNC_GAIN - 3'h1) begin
          sync_q <= 1'b1;
        end else begin
          good_q <= good_q + 3'h1;
        end
      end
    end
  end

  // Negotiation machine
  logic [20:0] lt_cyc;
  logic        tmr_done, an_go, rx_page;
  assign lt_cyc   = sgmii_q ? LT_SGMII : LT_SERDES;
  assign tmr_done = (tmr_q >= lt_cyc - 21'h1);
  assign an_go    = ena_q & an_ena_q;
  assign rx_page  = rx_src.cfg_valid & sync_q;

  gpa_pkg::gpa_an_state_t an_d;
  always_comb begin
    an_d = an_q;
    case (an_q)
      gpa_pkg::AN_FORCED_UP:   if (an_go) an_d = gpa_pkg::AN_RESTART;
      gpa_pkg::AN_RESTART:     if (tmr_done) an_d = gpa_pkg::AN_ABILITY;
      gpa_pkg::AN_ABILITY: begin
        if (rx_page) begin
          if (!sgmii_q && adv_q[`GPA_NP_BIT] && rx_src.cfg_word[`GPA_NP_BIT]) an_d = gpa_pkg::AN_NP_WAIT;
          else an_d = gpa_pkg::AN_IDLE_DETECT;
        end
      end
      gpa_pkg::AN_NP_WAIT:     if (np_loaded_q) an_d = gpa_pkg::AN_NP_EXCH;
      gpa_pkg::AN_NP_EXCH: begin
        if (rx_page) begin
          if (local_np_q[`GPA_NP_BIT] && rx_src.cfg_word[`GPA_NP_BIT]) an_d = gpa_pkg::AN_NP_WAIT;
          else an_d = gpa_pkg::AN_IDLE_DETECT;
        end
      end
      gpa_pkg::AN_IDLE_DETECT: if (tmr_done) an_d = gpa_pkg::AN_LINK_OK;
      gpa_pkg::AN_LINK_OK:     an_d = gpa_pkg::AN_LINK_OK;
      default:                 an_d = gpa_pkg::AN_RESTART;
    endcase
    if (!an_go) an_d = gpa_pkg::AN_FORCED_UP;
    else if (restart_q || los || (!sync_q && an_q != gpa_pkg::AN_RESTART)) an_d = gpa_pkg::AN_RESTART;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      an_q  <= gpa_pkg::AN_FORCED_UP;
      tmr_q <= 21'h0;
    end else begin
      an_q  <= an_d;
      tmr_q <= (an_d != an_q) ? 21'h0 : tmr_q + 21'h1;
    end
  end

  // One-shot bits: restart lasts one cycle after its write; next page loaded clears once acted on or on restart
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      restart_q   <= 1'b0;
      np_loaded_q <= 1'b0;
    end else begin
      restart_q <= w_an & avs_writedata[`GPA_B_AN_RESTART];
      if (w_np & avs_writedata[`GPA_B_NP_LOADED]) np_loaded_q <= 1'b1;
      else if (an_q == gpa_pkg::AN_NP_WAIT || an_d == gpa_pkg::AN_RESTART) np_loaded_q <= 1'b0;
    end
  end

  // Partner words, page flag, exchange-done bit
  logic page_set, ldown_set;
  assign page_set = rx_page & (an_q == gpa_pkg::AN_ABILITY || an_q == gpa_pkg::AN_NP_EXCH);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lp_adv_q <= `GPA_RST_WORD; lp_np_q <= `GPA_RST_WORD;
      page_q <= 1'b0; exch_done_q <= 1'b0;
    end else begin
      if (page_set && an_q == gpa_pkg::AN_ABILITY) lp_adv_q <= rx_src.cfg_word;
      if (page_set && an_q == gpa_pkg::AN_NP_EXCH) lp_np_q <= rx_src.cfg_word;
      // Set beats a simultaneous write-one clear
      page_q <= page_set | (page_q & ~(w_st & avs_writedata[`GPA_B_ST_PAGE]));
      if (an_d == gpa_pkg::AN_IDLE_DETECT && an_q != gpa_pkg::AN_IDLE_DETECT) exch_done_q <= 1'b1;
      else if (an_d == gpa_pkg::AN_RESTART || an_d == gpa_pkg::AN_FORCED_UP) exch_done_q <= 1'b0;
    end
  end

  // Link-down surveillance
  assign ldown_set = ena_q & ~in_link_state(an_q) & (down_q >= lt_cyc - 21'h1);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      down_q <= 21'h0; ldown_q <= 1'b0; ldown_cnt_q <= 8'h0;
    end else begin
      down_q <= (!ena_q || in_link_state(an_q) || ldown_set) ? 21'h0 : down_q + 21'h1;
      ldown_q <= ldown_set | (ldown_q & ~(w_st & avs_writedata[`GPA_B_ST_LDOWN]));
      if (ldown_set) ldown_cnt_q <= ldown_cnt_q + 8'h1;
    end
  end

  logic link_stat;
  assign link_stat = sgmii_q ? lp_adv_q[`GPA_SGMII_LINK_BIT] : sync_q;

  // Jitter pattern generator
  logic       pat_on;
  logic [10:0] frm_len;
  assign pat_on  = ena_q & (jp_sel_q != 3'h0);
  assign frm_len = (jp_sel_q == `GPA_JP_CR_LONG) ? `GPA_FRM_LONG : `GPA_FRM_SHORT;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !pat_on) begin
      pat_cnt_q <= 11'h0; lfsr_q <= `GPA_LFSR_SEED; pat_phase_q <= 1'b0; frm_q <= 1'b0;
    end else begin
      pat_phase_q <= ~pat_phase_q;
      lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ `GPA_LFSR_TAPS) : (lfsr_q >> 1);
      if (pat_cnt_q >= (frm_q ? frm_len : `GPA_FRM_GAP) - 11'h1) begin
        pat_cnt_q <= 11'h0;
        frm_q     <= ~frm_q;
      end else begin
        pat_cnt_q <= pat_cnt_q + 11'h1;
      end
    end
  end

  // Jitter test status: lock while sync holds, errors sticky and counted
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tp_lock_q <= 1'b0; tp_err_q <= 1'b0; tp_cnt_q <= 8'h0;
    end else begin
      tp_lock_q <= pat_on & sync_q;
      tp_err_q  <= (pat_on & rx_src.valid & rx_src.err) |
                   (tp_err_q & ~(w_tps & avs_writedata[`GPA_B_TP_ERR]));
      if (w_tps & avs_writedata[`GPA_B_TP_ERR]) tp_cnt_q <= 8'h0;
      else if (pat_on && rx_src.valid && rx_src.err && tp_cnt_q != 8'hff) tp_cnt_q <= tp_cnt_q + 8'h1;
    end
  end

  // Transmit path
  logic tx_data_ok;
  assign tx_data_ok = unidir_q | (in_link_state(an_q) & (an_go | sync_q));
  gpa_pkg::gpa_lane_t lane_tx_d;
  always_comb begin
    lane_tx_d = '0;
    if (!ena_q) begin
      lane_tx_d = '0;
    end else if (pat_on) begin
      lane_tx_d.valid = 1'b1;
      case (jp_sel_q)
        `GPA_JP_HF: lane_tx_d.data = `GPA_SYM_D21_5;
        `GPA_JP_LF: begin
          lane_tx_d.ctrl = 1'b1;
          lane_tx_d.data = `GPA_SYM_K28_7;
        end
        `GPA_JP_MF: begin
          lane_tx_d.ctrl = ~pat_phase_q;
          lane_tx_d.data = pat_phase_q ? `GPA_SYM_D10_2 : `GPA_SYM_K28_5;
        end
        `GPA_JP_CR_LONG, `GPA_JP_CR_SHORT: begin
          lane_tx_d.ctrl = ~frm_q;
          lane_tx_d.data = frm_q ? lfsr_q : `GPA_SYM_K28_5;
        end
        default: lane_tx_d.data = `GPA_SYM_K28_5;
      endcase
    end else if (tx_data_ok) begin
      lane_tx_d.valid = 1'b1;
      lane_tx_d.ctrl  = ~mac_tx.en;
      lane_tx_d.err   = mac_tx.er;
      lane_tx_d.data  = mac_tx.en ? mac_tx.data : `GPA_SYM_K28_5;
    end else if (an_q == gpa_pkg::AN_IDLE_DETECT) begin
      lane_tx_d.valid = 1'b1;
      lane_tx_d.ctrl  = 1'b1;
      lane_tx_d.data  = `GPA_SYM_K28_5;
    end else begin
      lane_tx_d.valid     = 1'b1;
      lane_tx_d.ctrl      = 1'b1;
      lane_tx_d.data      = `GPA_SYM_K28_5;
      lane_tx_d.cfg_valid = 1'b1;
      lane_tx_d.cfg_word  = cfg_tx_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_tx_q  <= `GPA_RST_WORD;
      lane_tx_q <= '0;
    end else begin
      case (an_d)
        gpa_pkg::AN_ABILITY: cfg_tx_q <= adv_q;
        gpa_pkg::AN_NP_EXCH: cfg_tx_q <= local_np_q;
        gpa_pkg::AN_NP_WAIT: cfg_tx_q <= cfg_tx_q;
        default:             cfg_tx_q <= `GPA_RST_WORD;
      endcase
      lane_tx_q <= lane_tx_d;
    end
  end
  assign lane_tx = lane_tx_q;

  // Receive path to the MAC; frames stop on loss of signal or lost sync
  logic rx_ok;
  assign rx_ok = ena_q & sync_q & ~los & ~pat_on;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mac_rx_q <= '0;
    end else begin
      mac_rx_q.en   <= rx_ok & rx_src.valid & ~rx_src.ctrl & ~rx_src.cfg_valid;
      mac_rx_q.er   <= rx_ok & rx_src.valid & rx_src.err;
      mac_rx_q.data <= rx_ok ? rx_src.data : 8'h00;
    end
  end
  assign mac_rx = mac_rx_q;

  // Read mux; unmapped offsets read zero
  logic [31:0] rd;
  always_comb begin
    rd = `GPA_RST_RDATA;
    case (avs_address)
      `GPA_OFF_CFG:       rd[`GPA_B_ENA] = ena_q;
      `GPA_OFF_MODE:      rd[1:0] = {unidir_q, sgmii_q};
      `GPA_OFF_SD_CFG:    rd[2:0] = {los_src_q, los_pol_q, los_react_q};
      `GPA_OFF_ANEG_CFG:  rd = {adv_q, 14'h0, restart_q, an_ena_q};
      `GPA_OFF_NP_CFG:    rd = {local_np_q, 15'h0, np_loaded_q};
      `GPA_OFF_LB_CFG:    rd[0] = loop_q;
      `GPA_OFF_ANEG_STAT: rd = {lp_adv_q, 13'h0, exch_done_q, page_q, an_q == gpa_pkg::AN_LINK_OK};
      `GPA_OFF_NP_STAT:   rd = {lp_np_q, 16'h0};
      `GPA_OFF_LINK_STAT: rd[7:0] = {1'b0, an_q, 1'b0, sd_val, sync_q, link_stat};
      `GPA_OFF_LDOWN_CNT: rd[7:0] = ldown_cnt_q;
      `GPA_OFF_STICKY:    rd[1:0] = {page_q, ldown_q};
      `GPA_OFF_TP_CFG:    rd[2:0] = jp_sel_q;
      `GPA_OFF_TP_STAT:   rd = {16'h0, tp_cnt_q, 6'h0, tp_err_q, tp_lock_q};
      default:            rd = `GPA_RST_RDATA;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_q <= `GPA_RST_RDATA;
    end else if (req & wait_q & avs_read) begin
      rdata_q <= rd;
    end
  end
  assign avs_readdata = rdata_q;
endmodule
`default_nettype wire

// ---- design/gpa_pkg.sv ----
package gpa_pkg;
  // Negotiation machine states
  typedef enum logic [2:0] {
    AN_FORCED_UP   = 3'b000,
    AN_RESTART     = 3'b001,
    AN_ABILITY     = 3'b010,
    AN_NP_WAIT     = 3'b011,
    AN_NP_EXCH     = 3'b100,
    AN_IDLE_DETECT = 3'b101,
    AN_LINK_OK     = 3'b110
  } gpa_an_state_t;

  // One code-group position on the lane, decoded
  typedef struct packed {
    logic        valid;
    logic        ctrl;
    logic        err;
    logic [7:0]  data;
    logic        cfg_valid;
    logic [15:0] cfg_word;
  } gpa_lane_t;

  // Byte-wide MAC side
  typedef struct packed {
    logic       en;
    logic       er;
    logic [7:0] data;
  } gpa_gmii_t;
endpackage

// ---- verif/gpa_lp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpa_lp_model (
  // Clock
  input  wire logic               clk_sys,
  // Bench control
  input  wire logic               good,
  input  wire logic               page_req,
  input  wire logic [15:0]        page_word,
  input  wire logic [7:0]         data,
  // Lane towards the coding layer
  output var  gpa_pkg::gpa_lane_t lane_rx
);
  initial lane_rx = '0;
  always @(posedge clk_sys) begin
    lane_rx.valid     <= 1'b1;
    lane_rx.ctrl      <= 1'b0;
    lane_rx.err       <= !good;
    // A broken line toggles, so a stale byte can never pass for data
    lane_rx.data      <= good ? data : ~lane_rx.data;
    lane_rx.cfg_valid <= page_req && good;
    lane_rx.cfg_word  <= page_req ? page_word : ~lane_rx.cfg_word;
  end
endmodule
`default_nettype wire

// ---- verif/gpa_pcs_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpa_pcs_sva (
  // Clock, reset, register bus
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic [5:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  // Data paths and signal detect
  input wire gpa_pkg::gpa_gmii_t mac_tx,
  input wire gpa_pkg::gpa_gmii_t mac_rx,
  input wire gpa_pkg::gpa_lane_t lane_rx,
  input wire gpa_pkg::gpa_lane_t lane_tx,
  input wire logic               sd_serdes,
  input wire logic               sd_optical
);
  // Shadows of the config bits that gate the receive path, kept from bus writes
  logic       ena_q;
  logic       lb_q;
  logic [2:0] sd_q;
  logic [2:0] tp_q;
  logic [7:0] src_q;
  wire logic  wr_ok = avs_write && !avs_waitrequest;
  wire logic  rd_ok = avs_read && !avs_waitrequest;
  wire logic  sd_raw = sd_q[2] ? sd_optical : sd_serdes;
  wire logic  sd_on = !(sd_raw ^ sd_q[1]);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ena_q <= 1'b0;
      lb_q  <= 1'b0;
      sd_q  <= 3'h2;
      tp_q  <= 3'h0;
    end else if (wr_ok) begin
      if (avs_address == 6'h00) ena_q <= avs_writedata[0];
      if (avs_address == 6'h14) lb_q <= avs_writedata[0];
      if (avs_address == 6'h08) sd_q <= avs_writedata[2:0];
      if (avs_address == 6'h2c) tp_q <= avs_writedata[2:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    src_q <= lb_q ? lane_tx.data : lane_rx.data;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_one_low: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_rx_off_disabled: assert property ((!ena_q) [*3] |-> !mac_rx.en)
    else $error("rx data while disabled");
  a_pattern_blocks_rx: assert property ((tp_q != 3'h0) [*3] |-> !mac_rx.en)
    else $error("rx data during pattern");
  a_los_blocks_rx: assert property ((sd_q[0] && !sd_on) [*5] |-> !mac_rx.en)
    else $error("rx data without signal");
  a_rx_from_lane: assert property (mac_rx.en |-> mac_rx.data == src_q)
    else $error("rx byte not from lane");
  a_unmapped_zero: assert property (rd_ok && avs_address > 6'h30 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_restart_cleared: assert property (rd_ok && avs_address == 6'h0c |-> !avs_readdata[1])
    else $error("restart bit stuck");
  c_rx_data: cover property (mac_rx.en);
  c_page_in: cover property (lane_rx.cfg_valid);
  c_np_read: cover property (rd_ok && avs_address == 6'h1c);
endmodule
`default_nettype wire

// ---- verif/gpa_pcs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpa_pcs_tb_top;
  localparam int LT_S = 20;
  localparam int LT_X = 50;
  logic               clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic               sd_serdes, sd_optical, good, page_req, lb_on;
  logic [5:0]         avs_address;
  logic [31:0]        avs_writedata, avs_readdata, rd;
  logic [15:0]        page_word;
  logic [7:0]         lp_data, tx_prev, c0;
  logic [8:0]         rx_exp;
  logic [5:0]         sd_tab [4] = '{6'b011010, 6'b111011, 6'b001001, 6'b101110};
  gpa_pkg::gpa_gmii_t mac_tx, mac_rx;
  gpa_pkg::gpa_lane_t lane_rx, lane_tx;
  int                 fail_count, n_checks, cyc, seed, t0, rx_seen;

  gpa_pcs #(.LT_SGMII_CYC(LT_S), .LT_SERDES_CYC(LT_X)) i_gpa_pcs (.clk_sys, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mac_tx, .mac_rx, .lane_rx, .lane_tx,
    .sd_serdes, .sd_optical);
  gpa_lp_model i_gpa_lp_model (.clk_sys, .good, .page_req, .page_word, .data(lp_data), .lane_rx);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tk(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Request held until waitrequest is sampled low; never re-raised in the release step
  task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rreg(logic [5:0] a, logic [31:0] e, logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e & m, rd & m);
  endtask

  // Restart first shows a zero page, so wait past it
  task automatic wait_tx(logic [15:0] w);
    int n;
    n = 0;
    tk(3);
    while (lane_tx.cfg_word !== w && n < 400) begin
      tk(1);
      n++;
    end
    chk("tx page", 32'(w), 32'(lane_tx.cfg_word));
  endtask

  task automatic send_page(logic [15:0] w);
    page_word <= w;
    page_req  <= 1'b1;
    t0 = cyc;
    tk(1);
    page_req  <= 1'b0;
    tk(3);
  endtask

  task automatic poll_done(int lt);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && n < 200) begin
      bus(1'b0, 6'h18, 32'h0);
      n++;
    end
    chk("done time", 1, 32'(cyc - t0 >= lt && cyc - t0 <= lt + 8));
  endtask

  // Receive model: each data byte comes from the lane, or from lane_tx in loopback, one cycle earlier
  always @(posedge clk_sys) begin
    cyc     <= cyc + 1;
    lp_data <= 8'($random(seed));
    mac_tx  <= '{en: 1'b1, er: 1'b0, data: 8'($random(seed))};
    tx_prev <= mac_tx.data;
    rx_exp  <= lb_on ? {lane_tx.err, lane_tx.data} : {lane_rx.err, lane_rx.data};
    if (mac_rx.en === 1'b1) begin
      rx_seen++;
      chk("mac_rx", 32'(rx_exp), 32'({mac_rx.er, mac_rx.data}));
    end
    if (cyc > 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    seed = 18216;
    {cyc, fail_count, n_checks, rx_seen, t0} = '0;
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {page_req, page_word, lb_on, sd_optical, lp_data} = '0;
    mac_tx = '0;
    sd_serdes = 1'b1;
    good = 1'b1;
    tk(4);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rreg(6'(i * 4), (i == 2) ? 32'h2 : 32'h0, (i == 8) ? 32'h70 : 32'hffffffff);
    end
    bus(1'b1, 6'h24, 32'hff);
    rreg(6'h24, 32'h0, 32'hff);
    bus(1'b1, 6'h00, 32'h1);
    tk(12);
    rreg(6'h20, 32'h7, 32'h77);
    chk("rx flow", 1, 32'(rx_seen > 0));
    good <= 1'b0;
    bus(1'b1, 6'h04, 32'h2);
    tk(8);
    rreg(6'h20, 32'h4, 32'h7);
    repeat (4) begin
      tk(1);
      chk("lane_tx", 32'(tx_prev), 32'(lane_tx.data));
    end
    bus(1'b1, 6'h04, 32'h0);
    good <= 1'b1;
    foreach (sd_tab[i]) begin
      bus(1'b1, 6'h08, 32'(sd_tab[i][5:3]));
      sd_serdes  <= sd_tab[i][2];
      sd_optical <= sd_tab[i][1];
      tk(6);
      rreg(6'h20, 32'(sd_tab[i][0]) << 2, 32'h4);
    end
    bus(1'b1, 6'h08, 32'h2);
    sd_serdes <= 1'b1;
    for (int p = 1; p < 6; p++) begin
      bus(1'b1, 6'h2c, 32'(p));
      tk(8);
      if (p < 3) chk("pattern", (p == 1) ? 32'hb5 : 32'hfc, 32'(lane_tx.data));
      rreg(6'h30, 32'h1, 32'h1);
    end
    bus(1'b1, 6'h2c, 32'h0);
    bus(1'b1, 6'h14, 32'h1);
    lb_on <= 1'b1;
    tk(30);
    bus(1'b1, 6'h14, 32'h0);
    lb_on <= 1'b0;
    bus(1'b1, 6'h0c, 32'h8123_0003);
    wait_tx(16'h8123);
    rreg(6'h0c, 32'h8123_0001, 32'hffff_0003);
    send_page(16'h8456);
    rreg(6'h18, 32'h8456_0002, 32'hffff_0007);
    rreg(6'h28, 32'h2, 32'h2);
    bus(1'b1, 6'h28, 32'h2);
    rreg(6'h28, 32'h0, 32'h2);
    bus(1'b1, 6'h10, 32'h0777_0001);
    wait_tx(16'h0777);
    send_page(16'h0999);
    rreg(6'h1c, 32'h0999_0000, 32'hffff_0000);
    rreg(6'h28, 32'h2, 32'h2);
    rreg(6'h18, 32'h4, 32'h5);
    rreg(6'h20, 32'h50, 32'h70);
    rreg(6'h10, 32'h0, 32'h1);
    poll_done(LT_X);
    rreg(6'h24, 32'h0, 32'hffff_ff00);
    c0 = rd[7:0];
    bus(1'b1, 6'h28, 32'h3);
    good <= 1'b0;
    tk(125);
    rreg(6'h24, 32'(c0 + 8'h2), 32'hff);
    rreg(6'h28, 32'h1, 32'h1);
    bus(1'b1, 6'h28, 32'h1);
    rreg(6'h28, 32'h0, 32'h1);
    good <= 1'b1;
    bus(1'b1, 6'h04, 32'h1);
    bus(1'b1, 6'h0c, 32'h4001_0003);
    wait_tx(16'h4001);
    send_page(16'h8001);
    rreg(6'h20, 32'h1, 32'h1);
    poll_done(LT_S);
    report_and_stop();
  end
endmodule

bind gpa_pcs gpa_pcs_sva i_gpa_pcs_sva (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .mac_tx, .mac_rx, .lane_rx, .lane_tx, .sd_serdes, .sd_optical);
`default_nettype wire
